/* File: trr_pkg.sv */
package trr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LOCAL = 8'h00;
    localparam logic [7:0] ADDR_REM_HI = 8'h01;
    localparam logic [7:0] ADDR_CFG_RD = 8'h03;
    localparam logic [7:0] ADDR_CFG_WR = 8'h09;
    localparam logic [7:0] ADDR_REM_LO = 8'h10;
    localparam int NUM_REGS = 22;

    // ------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [7:0] POINTER_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam int CFG_RANGE_BIT = 2;
    localparam logic [7:0] REM_LO_MASK = 8'hC0;
    localparam int FRAC_POS = 6;

    // ------------------------------------------------------------
    // Encoding
    // ------------------------------------------------------------
    localparam logic signed [9:0] TEMP_MIN_BIN = 10'sh000;
    localparam logic signed [9:0] TEMP_MAX_BIN = 10'sh07F;
    localparam logic signed [9:0] TEMP_MIN_EXT = -10'sh040;
    localparam logic signed [9:0] TEMP_MAX_EXT = 10'sh0BF;
    localparam logic signed [9:0] EXT_OFFSET = 10'sh040;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic remote;
        logic shorted;
        logic signed [9:0] degrees;
        logic [1:0] quarter;
    } trr_conv_s;

    typedef struct packed {
        logic wrPtr;
        logic wrData;
        logic rdData;
        logic [7:0] data;
    } trr_bus_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOCKED = 2'b01
    } trr_lock_e;

endpackage

/* File: trr_result_regs.sv */
`timescale 1ns/100ps
module trr_result_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Converter results
    input wire trr_pkg::trr_conv_s conv,
    // Register bus
    input wire trr_pkg::trr_bus_s bus,
    // Read data, range and pointer
    output logic [7:0] rdData,
    output logic extRange,
    output logic [7:0] pointer
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rstSync1_r;
    logic rstSync2_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    wire logic rstIn_b = rstSync2_r;

    // ------------------------------------------------------------
    // Encoding
    // ------------------------------------------------------------
    function automatic logic [7:0] encode(input logic signed [9:0] t, input logic ext);
        logic signed [9:0] v;
        v = t;
        if (ext) begin
            if (v < trr_pkg::TEMP_MIN_EXT) v = trr_pkg::TEMP_MIN_EXT;
            if (v > trr_pkg::TEMP_MAX_EXT) v = trr_pkg::TEMP_MAX_EXT;
            v = v + trr_pkg::EXT_OFFSET;
        end else begin
            if (v < trr_pkg::TEMP_MIN_BIN) v = trr_pkg::TEMP_MIN_BIN;
            if (v > trr_pkg::TEMP_MAX_BIN) v = trr_pkg::TEMP_MAX_BIN;
        end
        return v[7:0];
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // eight-bit registers, data-phase flag and lock state
    logic [7:0] local_r, local_nxt;
    logic [7:0] remHi_r, remHi_nxt;
    logic [7:0] remLo_r, remLo_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic expectData_r, expectData_nxt;
    trr_pkg::trr_lock_e lock_r, lock_nxt;

    logic ext;
    assign ext = cfg_r[trr_pkg::CFG_RANGE_BIT];

    always_comb begin
        local_nxt = local_r;
        remHi_nxt = remHi_r;
        remLo_nxt = remLo_r;
        cfg_nxt = cfg_r;
        ptr_nxt = ptr_r;
        rd_nxt = rd_r;
        expectData_nxt = expectData_r;
        lock_nxt = lock_r;

        if (conv.valid) begin
            if (!conv.remote) begin
                local_nxt = encode(conv.degrees, ext);
            end else if (!conv.shorted) begin
                if (lock_r == trr_pkg::ST_IDLE) begin
                    remHi_nxt = encode(conv.degrees, ext);
                    remLo_nxt = {conv.quarter, 6'h00} & trr_pkg::REM_LO_MASK;
                end
            end
        end

        if (bus.wrPtr) begin
            ptr_nxt = bus.data;
            expectData_nxt = 1'b1;
        end else if (bus.wrData && expectData_r) begin
            if (ptr_r == trr_pkg::ADDR_CFG_WR) begin
                cfg_nxt = bus.data;
            end
            expectData_nxt = 1'b0;
        end

        if (bus.rdData) begin
            if (ptr_r == trr_pkg::ADDR_LOCAL) begin
                rd_nxt = local_r;
            end else if (ptr_r == trr_pkg::ADDR_REM_HI) begin
                rd_nxt = remHi_r;
                lock_nxt = trr_pkg::ST_IDLE;
            end else if (ptr_r == trr_pkg::ADDR_REM_LO) begin
                rd_nxt = remLo_r;
                lock_nxt = trr_pkg::ST_LOCKED;
            end else if (ptr_r == trr_pkg::ADDR_CFG_RD) begin
                rd_nxt = cfg_r;
            end else begin
                rd_nxt = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstIn_b) begin
        if (!rstIn_b) begin
            local_r <= trr_pkg::RESULT_RST;
            remHi_r <= trr_pkg::RESULT_RST;
            remLo_r <= trr_pkg::RESULT_RST;
            cfg_r <= trr_pkg::CFG_RST;
            ptr_r <= trr_pkg::POINTER_RST;
            rd_r <= 8'h00;
            expectData_r <= 1'b0;
            lock_r <= trr_pkg::ST_IDLE;
        end else begin
            local_r <= local_nxt;
            remHi_r <= remHi_nxt;
            remLo_r <= remLo_nxt;
            cfg_r <= cfg_nxt;
            ptr_r <= ptr_nxt;
            rd_r <= rd_nxt;
            expectData_r <= expectData_nxt;
            lock_r <= lock_nxt;
        end
    end

    assign rdData = rd_r;
    assign extRange = cfg_r[trr_pkg::CFG_RANGE_BIT];
    assign pointer = ptr_r;

endmodule // trr_result_regs

/* File: trr_result_regs_props.sv */
`timescale 1ns/100ps
module trr_result_regs_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Inputs
    input wire trr_pkg::trr_conv_s conv,
    input wire trr_pkg::trr_bus_s bus,
    // Outputs
    input wire logic [7:0] rdData,
    input wire logic extRange,
    input wire logic [7:0] pointer
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence cfg_wr_s;
        bus.wrPtr && bus.data == trr_pkg::ADDR_CFG_WR ##1 bus.wrData && !bus.wrPtr;
    endsequence
    ptr_load_a: assert property (bus.wrPtr |=> pointer == $past(bus.data))
        else $error("pointer not loaded");
    ptr_hold_a: assert property (!bus.wrPtr |=> $stable(pointer))
        else $error("pointer moved");
    cfg_write_a: assert property (cfg_wr_s |=> extRange == $past(bus.data[2]))
        else $error("range bit not written");
    range_hold_a: assert property (!bus.wrData |=> $stable(extRange))
        else $error("range moved");
    cfg_read_a: assert property (bus.rdData && pointer == trr_pkg::ADDR_CFG_RD
        |=> rdData[2] == $past(extRange)) else $error("config read wrong");
    low_bits_a: assert property (bus.rdData && pointer == trr_pkg::ADDR_REM_LO
        |=> rdData[5:0] == 6'h00) else $error("low bits not zero");
    read_hold_a: assert property (!bus.rdData |=> $stable(rdData))
        else $error("read data moved");
    bin_clamp_a: assert property (bus.rdData && !extRange && pointer <= 8'h01
        |=> !rdData[7]) else $error("binary above 127");
endmodule // trr_result_regs_chk
bind trr_result_regs trr_result_regs_chk chk_u (.clk(clk), .rst_b(rst_b), .conv(conv),
    .bus(bus), .rdData(rdData), .extRange(extRange), .pointer(pointer));

/* File: trr_host_model.sv */
`timescale 1ns/100ps
module trr_host_model (
    // Clock
    input wire logic clk,
    // Bus
    input wire logic [7:0] rdData,
    output trr_pkg::trr_bus_s bus
);
    initial bus = '0;
    // Pointer byte then data byte; data line inverted once released
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) bus = '{1'b1, 1'b0, 1'b0, a};
        @(negedge clk) bus = '{1'b0, 1'b1, 1'b0, d};
        @(negedge clk) bus = '{1'b0, 1'b0, 1'b0, ~d};
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
        @(negedge clk) bus = '{1'b1, 1'b0, 1'b0, a};
        @(negedge clk) bus = '{1'b0, 1'b0, 1'b1, ~a};
        @(negedge clk) bus.rdData = 1'b0;
        q = rdData;
    endtask
endmodule // trr_host_model

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    trr_pkg::trr_conv_s conv = '0;
    trr_pkg::trr_bus_s bus;
    logic [7:0] rdData;
    logic [7:0] pointer;
    logic [7:0] q;
    logic extRange;
    int errors = 0;
    int checks = 0;
    int cycles = 0;
    int temps[3] = '{-55, 25, 150};
    logic [7:0] addrs[4] = '{8'h00, 8'h10, 8'h01, 8'h03};
    always #4 clk = ~clk;
    trr_result_regs dut_u (.clk(clk), .rst_b(rst_b), .conv(conv), .bus(bus),
        .rdData(rdData), .extRange(extRange), .pointer(pointer));
    trr_host_model host_u (.clk(clk), .rdData(rdData), .bus(bus));
    task automatic print_verdict;
        if (errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        host_u.rd_reg(a, q);
        cmp(q, exp);
    endtask
    task automatic cv(input logic rem, input logic sh, input int d, input logic [1:0] qt);
        @(negedge clk) conv = '{1'b1, rem, sh, 10'(d), qt};
        @(negedge clk) conv.valid = 1'b0;
    endtask
    // Expected register byte for a temperature
    function automatic logic [7:0] enc(input logic ext, input int d);
        int v;
        v = ext ? d + 64 : d;
        if (v < 0) v = 0;
        if (v > (ext ? 255 : 127)) v = ext ? 255 : 127;
        return 8'(v);
    endfunction
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        cmp(pointer, 8'h00);
        foreach (addrs[i]) chk(addrs[i], 8'h00);
        for (int r = 0; r < 2; r++) begin
            host_u.wr_reg(8'h09, r[0] ? 8'h04 : 8'h00);
            cmp({7'h00, extRange}, 8'(r));
            foreach (temps[i]) begin
                cv(1'b0, 1'b0, temps[i], 2'h0);
                chk(8'h00, enc(r[0], temps[i]));
            end
        end
        cv(1'b1, 1'b0, 25, 2'h3);
        chk(8'h10, 8'hC0);
        cv(1'b1, 1'b0, 50, 2'h0);
        chk(8'h01, enc(1'b1, 25));
        cv(1'b1, 1'b0, 50, 2'h1);
        chk(8'h01, enc(1'b1, 50));
        cv(1'b1, 1'b1, 100, 2'h0);
        chk(8'h01, enc(1'b1, 50));
        host_u.wr_reg(8'h00, 8'h55);
        chk(8'h00, enc(1'b1, 150));
        chk(8'h03, 8'h04);
        host_u.wr_reg(8'h10, 8'h3F);
        chk(8'h10, 8'h40);
        print_verdict();
    end
endmodule // testbench
